//--- inc/ccsh_regs.svh
// register offsets, command codes, bit positions and reset values of the command handler
`ifndef CCSH_REGS_SVH
`define CCSH_REGS_SVH

// apb byte offsets
`define CCSH_OFS_CMD      8'h00
`define CCSH_OFS_RESP     8'h04
`define CCSH_OFS_STB      8'h08
`define CCSH_OFS_ESE      8'h0C
`define CCSH_OFS_SRE      8'h10
`define CCSH_OFS_SET      8'h14
`define CCSH_OFS_OPER     8'h18

// command codes, written to cmd[7:0], argument in cmd[15:8]
`define CCSH_CMD_CLS      8'h01
`define CCSH_CMD_ESE      8'h02
`define CCSH_CMD_ESE_Q    8'h03
`define CCSH_CMD_ESR_Q    8'h04
`define CCSH_CMD_SRE      8'h05
`define CCSH_CMD_SRE_Q    8'h06
`define CCSH_CMD_STB_Q    8'h07
`define CCSH_CMD_IDN_Q    8'h08
`define CCSH_CMD_RST      8'h09
`define CCSH_CMD_TRG      8'h0A
`define CCSH_CMD_OPT_Q    8'h0B
`define CCSH_CMD_OPC      8'h0C
`define CCSH_CMD_OPC_Q    8'h0D
`define CCSH_CMD_WAI      8'h0E
`define CCSH_CMD_COND_Q   8'h10
`define CCSH_CMD_EVNT_Q   8'h11
`define CCSH_CMD_MODE     8'h20
`define CCSH_CMD_TEST_AC  8'h21
`define CCSH_CMD_TEST_DC  8'h22
`define CCSH_CMD_TEST_Q   8'h23
`define CCSH_CMD_ITRIG    8'h24
`define CCSH_CMD_RANGE    8'h25
`define CCSH_CMD_RANGE_Q  8'h26
`define CCSH_CMD_FMAJ     8'h27
`define CCSH_CMD_FMIN     8'h28
`define CCSH_CMD_FMAJ_Q   8'h29
`define CCSH_CMD_FMIN_Q   8'h2A
`define CCSH_CMD_BIAS     8'h2B
`define CCSH_CMD_BIAS_Q   8'h2C

// event status register bits
`define CCSH_ESR_OPC      0
`define CCSH_ESR_QYE      2
`define CCSH_ESR_EXE      4
`define CCSH_ESR_CME      5
`define CCSH_ESR_PON      7
// status byte bits
`define CCSH_STB_MAV      4
`define CCSH_STB_ESB      5
`define CCSH_STB_MSS      6
// operation condition / event bits
`define CCSH_OPER_CAL     0
`define CCSH_OPER_MEAS    4

// reset values, service enable mask, opc answer and function limit
`define CCSH_ESR_RST      8'h80
`define CCSH_SRE_MASK     8'hBF
`define CCSH_OPC_ANSWER   32'h0000_0001
`define CCSH_FUNC_MAX     3'h5
`define CCSH_FMAJ_RST     3'h1
`define CCSH_FMIN_RST     3'h3

`endif

//--- inc/ccsh_pkg.sv
// types of the common command and status handler
package ccsh_pkg;

  // measurement mode selected by the controller
  typedef enum logic [1:0] {
    MODE_IMP,
    MODE_TRAN,
    MODE_INS,
    MODE_BIN
  } ccsh_mode_e;

  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ccsh_apb_s;

  // measurement settings restored by reset command
  typedef struct packed {
    ccsh_mode_e  mode;
    logic        test_dc;
    logic        range_auto;
    logic [2:0]  range_num;
    logic [2:0]  func_major;
    logic [2:0]  func_minor;
    logic        bias_int;
    logic        bias_ext;
  } ccsh_set_s;

  // whole state of the handler
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [7:0]  esr;
    logic [7:0]  ese;
    logic [7:0]  sre;
    logic [7:0]  stb;
    logic [15:0] oper_evt;
    logic [31:0] resp;
    logic        mav;
    ccsh_set_s   set;
    logic        meas_busy;
    logic        meas_start;
    logic        reject;
  } ccsh_state_s;

endpackage

//--- verilog/ccsh_handler.sv
// common command interpreter and status reporting with apb register access
//
// How it works
// - clear status empties event register and summaries
// - event enable command loads enable register
// - event enable query returns enable, 0..255
// - event register query returns then clears
// - service enable stored with bit 6 dropped
// - service enable query shows bit 6 zero
// - status byte query carries summary in bit6
// - reset command restores power-up settings
// - trigger or get starts measurement, no result
// - operation complete command sets its event bit
// - operation complete query always answers one
// - wait-to-continue accepted, does nothing
// - option query returns fitted options word
// - identity query returns four ordered fields
// - out-of-mode setting rejected with error flag
// - impedance trigger starts selected ac/dc measurement
// - range command sets auto or held range
// - function command assigns major/minor result
// - bias command drives bias, query reports
// - summary bit6 when status and enable overlap
// - event summary bit5 when events enabled
// - power-on bit set until register read or status clear
// - condition bit0 calibrating, bit4 measuring
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ns
`include "ccsh_regs.svh"

module ccsh_handler #(
  parameter logic [7:0] MFR_CODE  = 8'h5A, // arbitrary value
  parameter logic [7:0] MODEL_NUM = 8'h42, // arbitrary value
  parameter logic [7:0] SW_REV    = 8'h10, // arbitrary value
  parameter logic [31:0] OPTIONS  = 32'h0000_0000,
  parameter int unsigned NUM_RANGES = 8
) (
  input  wire logic                i_core_clk,
  input  wire logic                i_rst,
  input  wire ccsh_pkg::ccsh_apb_s i_apb,
  input  wire logic                i_get,
  input  wire logic                i_meas_done,
  input  wire logic                i_cal_busy,
  input  wire logic                i_dev_error,
  output logic                     o_pready,
  output logic                     o_pslverr,
  output logic [31:0]              o_prdata,
  output logic                     o_meas_start,
  output ccsh_pkg::ccsh_set_s      o_settings,
  output logic                     o_srq,
  output logic                     o_reject
);

  // elaboration check on range count
  if (NUM_RANGES < 1 || NUM_RANGES > 8) begin : g_bad_ranges
    $error("NUM_RANGES must lie in 1..8");
  end

  // power-up measurement settings, also restored by the reset command
  localparam ccsh_pkg::ccsh_set_s SET_RST = '{
    mode:       ccsh_pkg::MODE_IMP,
    test_dc:    1'b0,
    range_auto: 1'b1,
    range_num:  3'h0,
    func_major: `CCSH_FMAJ_RST,
    func_minor: `CCSH_FMIN_RST,
    bias_int:   1'b0,
    bias_ext:   1'b0
  };

  // registered state and its next value
  ccsh_pkg::ccsh_state_s s_r;
  ccsh_pkg::ccsh_state_s s_nxt;

  // decode helpers
  logic        acc;
  logic        wr_cmd;
  logic [7:0]  code;
  logic [7:0]  arg;
  logic [15:0] cond;
  logic        in_imp;
  logic        mapped;
  logic [31:0] rd_val;

  // apb phase decode
  assign acc    = i_apb.psel && i_apb.penable && s_r.pready;
  assign wr_cmd = acc && i_apb.pwrite && (i_apb.paddr == `CCSH_OFS_CMD);
  assign code   = i_apb.pwdata[7:0];
  assign arg    = i_apb.pwdata[15:8];
  assign in_imp = (s_r.set.mode == ccsh_pkg::MODE_IMP);

  // operation condition word
  always_comb begin
    cond                  = 16'h0000;
    cond[`CCSH_OPER_CAL]  = i_cal_busy;
    cond[`CCSH_OPER_MEAS] = s_r.meas_busy;
  end

  // read mux for the setup cycle
  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    case (i_apb.paddr)
      `CCSH_OFS_CMD:  rd_val = 32'h0000_0000;
      `CCSH_OFS_RESP: rd_val = s_r.resp;
      `CCSH_OFS_STB:  rd_val = {24'h00_0000, s_r.stb};
      `CCSH_OFS_ESE:  rd_val = {24'h00_0000, s_r.ese};
      `CCSH_OFS_SRE:  rd_val = {24'h00_0000, s_r.sre};
      `CCSH_OFS_SET:  rd_val = {17'h0_0000, s_r.set};
      `CCSH_OFS_OPER: rd_val = {s_r.oper_evt, cond};
      default:        mapped = 1'b0;
    endcase
  end

  // next state
  always_comb begin
    // per-cycle set, keep and answer flags
    logic [7:0]  esr_set;
    logic [7:0]  esr_keep;
    logic        new_resp;
    logic        resp_read;
    logic [15:0] evt_set;
    esr_set   = 8'h00;
    esr_keep  = s_r.esr;
    new_resp  = 1'b0;
    resp_read = 1'b0;
    evt_set   = 16'h0000;
    s_nxt     = s_r;

    // one-cycle pulses
    s_nxt.meas_start = 1'b0;
    s_nxt.reject     = 1'b0;

    // apb answer: ready in the access cycle after setup
    s_nxt.pready  = i_apb.psel && !i_apb.penable;
    s_nxt.pslverr = i_apb.psel && !i_apb.penable && !mapped;
    if (i_apb.psel && !i_apb.penable && !i_apb.pwrite) begin
      s_nxt.prdata = rd_val;
    end
    if (acc && !i_apb.pwrite && i_apb.paddr == `CCSH_OFS_RESP) begin
      resp_read = 1'b1;
    end

    // measurement completion, event bits merged after the commands
    if (s_r.meas_busy && i_meas_done) begin
      s_nxt.meas_busy          = 1'b0;
      evt_set[`CCSH_OPER_MEAS] = 1'b1;
    end
    if (i_cal_busy) begin
      evt_set[`CCSH_OPER_CAL] = 1'b1;
    end

    // group execute trigger
    if (i_get) begin
      s_nxt.meas_start = 1'b1;
      s_nxt.meas_busy  = 1'b1;
    end

    // command interpreter
    if (wr_cmd) begin
      case (code)
        // status clear
        `CCSH_CMD_CLS: begin
          esr_keep     = 8'h00;
          s_nxt.oper_evt = 16'h0000;
          s_nxt.mav    = 1'b0;
        end

        // event enable set and query
        `CCSH_CMD_ESE: s_nxt.ese = arg;
        `CCSH_CMD_ESE_Q: begin
          s_nxt.resp = {24'h00_0000, s_r.ese};
          new_resp   = 1'b1;
        end

        // event register read, power-on bit cleared too
        `CCSH_CMD_ESR_Q: begin
          s_nxt.resp = {24'h00_0000, s_r.esr};
          new_resp   = 1'b1;
          esr_keep   = 8'h00;
        end

        // service enable, bit 6 never stored
        `CCSH_CMD_SRE: s_nxt.sre = arg & `CCSH_SRE_MASK;
        `CCSH_CMD_SRE_Q: begin
          s_nxt.resp = {24'h00_0000, s_r.sre & `CCSH_SRE_MASK};
          new_resp   = 1'b1;
        end

        // status byte with summary in bit 6
        `CCSH_CMD_STB_Q: begin
          s_nxt.resp = {24'h00_0000, s_r.stb};
          new_resp   = 1'b1;
        end

        // identity word: maker, model, zero, revision
        `CCSH_CMD_IDN_Q: begin
          s_nxt.resp = {MFR_CODE, MODEL_NUM, 8'h00, SW_REV};
          new_resp   = 1'b1;
        end

        // settings back to power-up values
        `CCSH_CMD_RST: begin
          s_nxt.set = SET_RST;
        end

        // direct measurement, answer register untouched
        `CCSH_CMD_TRG: begin
          s_nxt.meas_start = 1'b1;
          s_nxt.meas_busy  = 1'b1;
        end

        // fitted options word
        `CCSH_CMD_OPT_Q: begin
          s_nxt.resp = OPTIONS;
          new_resp   = 1'b1;
        end

        // operation complete command and query
        `CCSH_CMD_OPC: esr_set[`CCSH_ESR_OPC] = 1'b1;
        `CCSH_CMD_OPC_Q: begin
          s_nxt.resp = `CCSH_OPC_ANSWER;
          new_resp   = 1'b1;
        end

        // already sequential, nothing to wait for
        `CCSH_CMD_WAI: s_nxt.reject = 1'b0;

        // operation condition and event words
        `CCSH_CMD_COND_Q: begin
          s_nxt.resp = {16'h0000, cond};
          new_resp   = 1'b1;
        end
        `CCSH_CMD_EVNT_Q: begin
          s_nxt.resp     = {16'h0000, s_r.oper_evt};
          new_resp       = 1'b1;
          s_nxt.oper_evt = 16'h0000;
        end

        // mode select, every mode accepted
        `CCSH_CMD_MODE: begin
          s_nxt.set.mode = ccsh_pkg::ccsh_mode_e'(arg[1:0]);
        end

        // impedance test, trigger, range and bias
        `CCSH_CMD_TEST_AC, `CCSH_CMD_TEST_DC, `CCSH_CMD_TEST_Q, `CCSH_CMD_ITRIG,
        `CCSH_CMD_RANGE, `CCSH_CMD_RANGE_Q, `CCSH_CMD_BIAS, `CCSH_CMD_BIAS_Q: begin
          if (!in_imp) begin
            s_nxt.reject              = 1'b1;
            esr_set[`CCSH_ESR_EXE]    = 1'b1;
          end else if (code == `CCSH_CMD_TEST_AC || code == `CCSH_CMD_TEST_DC) begin
            s_nxt.set.test_dc = (code == `CCSH_CMD_TEST_DC);
          end else if (code == `CCSH_CMD_TEST_Q) begin
            s_nxt.resp = {31'h0000_0000, s_r.set.test_dc};
            new_resp   = 1'b1;
          end else if (code == `CCSH_CMD_ITRIG) begin
            s_nxt.meas_start = 1'b1;
            s_nxt.meas_busy  = 1'b1;
          end else if (code == `CCSH_CMD_RANGE) begin
            if (!arg[7] && 32'(arg[2:0]) >= NUM_RANGES) begin
              s_nxt.reject           = 1'b1;
              esr_set[`CCSH_ESR_EXE] = 1'b1;
            end else begin
              s_nxt.set.range_auto = arg[7];
              s_nxt.set.range_num  = arg[2:0];
            end
          end else if (code == `CCSH_CMD_RANGE_Q) begin
            s_nxt.resp = {24'h00_0000, s_r.set.range_auto, 4'h0, s_r.set.range_num};
            new_resp   = 1'b1;
          end else if (code == `CCSH_CMD_BIAS) begin
            s_nxt.set.bias_int = arg[0];
            s_nxt.set.bias_ext = arg[1];
          end else begin
            s_nxt.resp = {30'h0000_0000, s_r.set.bias_ext, s_r.set.bias_int};
            new_resp   = 1'b1;
          end
        end

        // result functions, ac test only
        `CCSH_CMD_FMAJ, `CCSH_CMD_FMIN, `CCSH_CMD_FMAJ_Q, `CCSH_CMD_FMIN_Q: begin
          if (!in_imp || s_r.set.test_dc || arg[2:0] > `CCSH_FUNC_MAX) begin
            s_nxt.reject           = 1'b1;
            esr_set[`CCSH_ESR_EXE] = 1'b1;
          end else if (code == `CCSH_CMD_FMAJ) begin
            s_nxt.set.func_major = arg[2:0];
          end else if (code == `CCSH_CMD_FMIN) begin
            s_nxt.set.func_minor = arg[2:0];
          end else if (code == `CCSH_CMD_FMAJ_Q) begin
            s_nxt.resp = {29'h0000_0000, s_r.set.func_major};
            new_resp   = 1'b1;
          end else begin
            s_nxt.resp = {29'h0000_0000, s_r.set.func_minor};
            new_resp   = 1'b1;
          end
        end

        // unknown code: command error
        default: esr_set[`CCSH_ESR_CME] = 1'b1;
      endcase
    end

    // operation events raised in the cycle of a clear survive it
    s_nxt.oper_evt = s_nxt.oper_evt | evt_set;

    // query while answer unread loses old answer
    if (new_resp && s_r.mav && !resp_read) begin
      esr_set[`CCSH_ESR_QYE] = 1'b1;
    end
    // set wins over clear
    s_nxt.esr = esr_keep | esr_set;
    // message available follows answers and their reads
    if (new_resp) begin
      s_nxt.mav = 1'b1;
    end else if (resp_read) begin
      s_nxt.mav = 1'b0;
    end

    // status byte summaries
    s_nxt.stb                = 8'h00;
    s_nxt.stb[2]             = i_dev_error;
    s_nxt.stb[`CCSH_STB_MAV] = s_nxt.mav;
    s_nxt.stb[`CCSH_STB_ESB] = |(s_nxt.esr & s_nxt.ese);
    s_nxt.stb[`CCSH_STB_MSS] = |(s_nxt.stb & s_nxt.sre & `CCSH_SRE_MASK);
  end

  // state register, power-on bit raised at reset
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r            <= '0;
      s_r.esr        <= `CCSH_ESR_RST;
      s_r.set        <= SET_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from state
  assign o_pready     = s_r.pready;
  assign o_pslverr    = s_r.pslverr;
  assign o_prdata     = s_r.prdata;
  assign o_meas_start = s_r.meas_start;
  assign o_settings   = s_r.set;
  assign o_srq        = s_r.stb[`CCSH_STB_MSS];
  assign o_reject     = s_r.reject;

endmodule

//--- test/ccsh_handler_asserts.sv
// port checker of the command handler
`timescale 1ns/1ns
`include "ccsh_regs.svh"
module ccsh_handler_asserts (
  input wire logic                i_core_clk,
  input wire logic                i_rst,
  input wire ccsh_pkg::ccsh_apb_s i_apb,
  input wire logic                i_get,
  input wire logic                o_pready,
  input wire logic                o_pslverr,
  input wire logic [31:0]         o_prdata,
  input wire logic                o_meas_start,
  input wire ccsh_pkg::ccsh_set_s o_settings,
  input wire logic                o_srq,
  input wire logic                o_reject
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic acc;
  logic rdc;
  logic wcmd;
  // access edge decode
  assign acc  = i_apb.psel & i_apb.penable & o_pready;
  assign rdc  = acc & ~i_apb.pwrite;
  assign wcmd = acc & i_apb.pwrite & (i_apb.paddr == `CCSH_OFS_CMD);
  property p_ready;
    i_apb.psel && !i_apb.penable |=> o_pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no pready after setup");
  property p_err;
    o_pslverr |-> o_pready;
  endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_stb;
    rdc && i_apb.paddr == `CCSH_OFS_STB |-> o_prdata[6] == o_srq && o_prdata[31:8] == 24'h0;
  endproperty
  a_stb: assert property (p_stb) else $error("status byte bit6 differs from srq");
  property p_sre;
    rdc && i_apb.paddr == `CCSH_OFS_SRE |-> o_prdata[6] == 1'b0 && o_prdata[31:8] == 24'h0;
  endproperty
  a_sre: assert property (p_sre) else $error("service enable bit6 set");
  property p_ese;
    rdc && i_apb.paddr == `CCSH_OFS_ESE |-> o_prdata[31:8] == 24'h0;
  endproperty
  a_ese: assert property (p_ese) else $error("event enable above 255");
  property p_oper;
    rdc && i_apb.paddr == `CCSH_OFS_OPER |-> (o_prdata[15:0] & 16'hFFEE) == 16'h0;
  endproperty
  a_oper: assert property (p_oper) else $error("unused condition bit set");
  property p_rej;
    o_reject |-> $past(wcmd) && $stable(o_settings);
  endproperty
  a_rej: assert property (p_rej) else $error("reject without command or with change");
  property p_set;
    !$past(wcmd) |-> $stable(o_settings);
  endproperty
  a_set: assert property (p_set) else $error("settings moved without command");
  property p_start;
    o_meas_start |-> $past(wcmd) || $past(i_get);
  endproperty
  a_start: assert property (p_start) else $error("start without cause");
  property p_pulse;
    o_meas_start |=> !o_meas_start;
  endproperty
  a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
endmodule
bind ccsh_handler ccsh_handler_asserts ccsh_handler_asserts_i (
  .i_core_clk  (i_core_clk),
  .i_rst       (i_rst),
  .i_apb       (i_apb),
  .i_get       (i_get),
  .o_pready    (o_pready),
  .o_pslverr   (o_pslverr),
  .o_prdata    (o_prdata),
  .o_meas_start(o_meas_start),
  .o_settings  (o_settings),
  .o_srq       (o_srq),
  .o_reject    (o_reject)
);

//--- test/ccsh_ctl_model.sv
// controller model issuing apb transfers to the handler
`timescale 1ns/1ns
module ccsh_ctl_model (
  input  wire logic         i_core_clk,
  input  wire logic         i_pready,
  input  wire logic         i_pslverr,
  input  wire logic [31:0]  i_prdata,
  output ccsh_pkg::ccsh_apb_s o_apb
);
  initial o_apb = '0;
  // one transfer, request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge i_core_clk);
    o_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge i_core_clk);
    o_apb.penable <= 1'b1;
    do begin
      @(posedge i_core_clk);
    end while (i_pready !== 1'b1);
    q = i_prdata;
    e = i_pslverr;
    // released lines show the inverse, never the last value
    o_apb <= '{psel: 1'b0, penable: 1'b0, pwrite: ~w, paddr: ~a, pwdata: ~d};
  endtask
endmodule

//--- test/tb.sv
// testbench of the command and status handler
`timescale 1ns/1ns
`include "ccsh_regs.svh"
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin mismatches++; \
  $display("BAD %0t got %h exp %h", $time, (g), (x)); end end
module tb;
  localparam logic [7:0]  MFR  = 8'hC3; // arbitrary value
  localparam logic [7:0]  MDL  = 8'h3C; // arbitrary value
  localparam logic [7:0]  REV  = 8'h21; // arbitrary value
  localparam logic [31:0] OPTS = 32'h0000_0003;
  logic                i_core_clk;
  logic                i_rst;
  logic                i_get;
  logic                i_meas_done;
  logic                i_cal_busy;
  logic                i_dev_error;
  ccsh_pkg::ccsh_apb_s apb;
  logic                o_pready;
  logic                o_pslverr;
  logic [31:0]         o_prdata;
  logic                o_meas_start;
  ccsh_pkg::ccsh_set_s o_settings;
  ccsh_pkg::ccsh_set_s s;
  ccsh_pkg::ccsh_set_s d;
  logic                o_srq;
  logic                o_reject;
  logic [31:0]         q;
  logic                e;
  int                  mismatches;
  int                  checked;
  int                  starts;
  int                  rejects;
  ccsh_handler #(.MFR_CODE(MFR), .MODEL_NUM(MDL), .SW_REV(REV), .OPTIONS(OPTS)) ccsh_handler_i (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_apb(apb), .i_get(i_get),
    .i_meas_done(i_meas_done), .i_cal_busy(i_cal_busy), .i_dev_error(i_dev_error),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata),
    .o_meas_start(o_meas_start), .o_settings(o_settings), .o_srq(o_srq), .o_reject(o_reject));
  ccsh_ctl_model ctl_i (.i_core_clk(i_core_clk), .i_pready(o_pready), .i_pslverr(o_pslverr),
    .i_prdata(o_prdata), .o_apb(apb));
  // clock
  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end
  // pulse counters
  always @(posedge i_core_clk) begin
    if (o_meas_start === 1'b1) starts <= starts + 1;
    if (o_reject === 1'b1) rejects <= rejects + 1;
  end
  task cmd(input logic [7:0] c, input logic [7:0] a);
    ctl_i.xfer(1'b1, `CCSH_OFS_CMD, {16'h0, a, c}, q, e);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    ctl_i.xfer(1'b0, a, 32'h0, q, e);
    `CHK(q, x)
  endtask
  task qry(input logic [7:0] c, input logic [31:0] x);
    cmd(c, 8'h00);
    rd(`CCSH_OFS_RESP, x);
  endtask
  task rej(input logic [7:0] c, input logic [7:0] a);
    int n;
    n = rejects;
    cmd(c, a);
    repeat (2) @(posedge i_core_clk);
    `CHK(rejects, n + 1)
    `CHK(o_settings, s)
  endtask
  task done_p;
    @(posedge i_core_clk);
    i_meas_done <= 1'b1;
    @(posedge i_core_clk);
    i_meas_done <= 1'b0;
  endtask
  task final_report;
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #(40 * 5000);
    mismatches++;
    final_report();
  end
  // test sequence
  initial begin
    i_rst = 1'b1;
    i_get = 1'b0;
    i_meas_done = 1'b0;
    i_cal_busy = 1'b0;
    i_dev_error = 1'b0;
    d = '{mode: ccsh_pkg::MODE_IMP, test_dc: 1'b0, range_auto: 1'b1, range_num: 3'h0,
          func_major: 3'h1, func_minor: 3'h3, bias_int: 1'b0, bias_ext: 1'b0};
    s = d;
    repeat (6) @(posedge i_core_clk);
    i_rst <= 1'b0;
    `CHK(o_settings, d)
    qry(`CCSH_CMD_ESR_Q, 32'h80);
    qry(`CCSH_CMD_ESR_Q, 32'h00);
    cmd(`CCSH_CMD_ESE, 8'hA5);
    qry(`CCSH_CMD_ESE_Q, 32'hA5);
    cmd(`CCSH_CMD_SRE, 8'hFF);
    qry(`CCSH_CMD_SRE_Q, 32'hBF);
    rd(`CCSH_OFS_SRE, 32'hBF);
    rd(`CCSH_OFS_ESE, 32'hA5);
    cmd(`CCSH_CMD_ESE, 8'h01);
    cmd(`CCSH_CMD_SRE, 8'h20);
    cmd(`CCSH_CMD_OPC, 8'h00);
    rd(`CCSH_OFS_STB, 32'h60);
    `CHK(o_srq, 1'b1)
    i_dev_error <= 1'b1;
    cmd(`CCSH_CMD_SRE, 8'h04);
    rd(`CCSH_OFS_STB, 32'h64);
    qry(`CCSH_CMD_STB_Q, 32'h64);
    i_dev_error <= 1'b0;
    cmd(`CCSH_CMD_CLS, 8'h00);
    rd(`CCSH_OFS_STB, 32'h00);
    `CHK(o_srq, 1'b0)
    qry(`CCSH_CMD_OPC_Q, 32'h1);
    qry(`CCSH_CMD_OPT_Q, OPTS);
    qry(`CCSH_CMD_IDN_Q, {MFR, MDL, 8'h00, REV});
    cmd(`CCSH_CMD_WAI, 8'h00);
    qry(`CCSH_CMD_ESR_Q, 32'h00);
    cmd(8'h7F, 8'h00);
    qry(`CCSH_CMD_ESR_Q, 32'h20);
    rd(8'h40, 32'h0);
    `CHK(e, 1'b1)
    cmd(`CCSH_CMD_RANGE, 8'h03);
    qry(`CCSH_CMD_RANGE_Q, 32'h03);
    cmd(`CCSH_CMD_FMAJ, 8'h02);
    cmd(`CCSH_CMD_FMIN, 8'h04);
    qry(`CCSH_CMD_FMAJ_Q, 32'h2);
    qry(`CCSH_CMD_FMIN_Q, 32'h4);
    cmd(`CCSH_CMD_BIAS, 8'h03);
    qry(`CCSH_CMD_BIAS_Q, 32'h3);
    s = '{ccsh_pkg::MODE_IMP, 1'b0, 1'b0, 3'h3, 3'h2, 3'h4, 1'b1, 1'b1};
    `CHK(o_settings, s)
    rd(`CCSH_OFS_SET, {17'h0_0000, s});
    rej(`CCSH_CMD_FMAJ, 8'h06);
    cmd(`CCSH_CMD_TEST_DC, 8'h00);
    qry(`CCSH_CMD_TEST_Q, 32'h1);
    s.test_dc = 1'b1;
    rej(`CCSH_CMD_FMIN, 8'h01);
    cmd(`CCSH_CMD_MODE, 8'h01);
    s.mode = ccsh_pkg::MODE_TRAN;
    rej(`CCSH_CMD_RANGE, 8'h80);
    rej(`CCSH_CMD_ITRIG, 8'h00);
    qry(`CCSH_CMD_ESR_Q, 32'h10);
    cmd(`CCSH_CMD_RST, 8'h00);
    @(posedge i_core_clk);
    `CHK(o_settings, d)
    i_cal_busy <= 1'b1;
    cmd(`CCSH_CMD_ITRIG, 8'h00);
    qry(`CCSH_CMD_COND_Q, 32'h11);
    `CHK(starts, 1)
    done_p();
    qry(`CCSH_CMD_COND_Q, 32'h01);
    i_cal_busy <= 1'b0;
    cmd(`CCSH_CMD_TRG, 8'h00);
    rd(`CCSH_OFS_STB, 32'h00);
    qry(`CCSH_CMD_EVNT_Q, 32'h11);
    rd(`CCSH_OFS_OPER, 32'h0000_0010);
    done_p();
    @(posedge i_core_clk);
    i_get <= 1'b1;
    @(posedge i_core_clk);
    i_get <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    `CHK(starts, 3)
    // second power cycle in mid-run
    cmd(`CCSH_CMD_RANGE, 8'h02);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_rst <= 1'b0;
    `CHK(o_settings, d)
    qry(`CCSH_CMD_ESR_Q, 32'h80);
    final_report();
  end
endmodule
